// ---- hdl/phvc_consts.svh ----
// Constants for the PLL holdover and VCO calibration control block.
// Assumes the register slave sits on AXI4-Lite with 32-bit aligned words.
// Functional notes
// - Auto holdover tri-states the charge pump when lock is lost.
// - Holdover entry follows lock pin level; comparator off means always high.
// - Charge pump stays tri-stated while no reference edges arrive.
// - Leaving tri-state on a reference event resets the B counter only.
// - After exit, automatic re-entry waits for lock and the lock pin going high.
// - Holdover follows selected reference; switchover loss lasts until next edge.
// - Two-bit lock count sets consecutive in-window cycles; 00 means five.
// - Lock pin control code 000100 selects current source lock detect.
// - Holdover enable clear inhibits both external and automatic holdover.
// - External holdover bit zero selects automatic holdover.
// - Three frequency monitors flag references or VCO/external clock too slow.
// - One bit picks normal or extended reference monitor threshold.
// - Calibration runs from divided reference and needs reference present.
// - Power-up auto-load starts a calibration when reference is valid.
// - Later calibrations start on committed 0-to-1 calibrate transition.
// - Read-only status bit is one when calibration finished.
// - Calibration holds outputs in sync, releases it when tuning ends.
// - Calibration clock is detector rate over two-bit divider; keep under 6.25 MHz.
// - Calibration takes exactly 4400 calibration clock cycles.
// - Leaving holdover waits for next reference edge; no reference keeps tri-state.
// - Lock indication stays until one cycle exceeds unlock threshold.
`ifndef PHVC_CONSTS_SVH
`define PHVC_CONSTS_SVH
`define PHVC_ADDR_PLLCTL 12'h018
`define PHVC_ADDR_LDPIN 12'h01A
`define PHVC_ADDR_REFSEL 12'h01C
`define PHVC_ADDR_HOLDCTL 12'h01D
`define PHVC_ADDR_STATUS 12'h01F
`define PHVC_ADDR_VCODIV 12'h1E0
`define PHVC_ADDR_UPDATE 12'h232
`define PHVC_BIT_CAL 0
`define PHVC_BIT_CALDIV_LO 1
`define PHVC_BIT_DLD_DIS 3
`define PHVC_BIT_LDCNT_LO 5
`define PHVC_BIT_THRESH 6
`define PHVC_BIT_HOLD_EN 0
`define PHVC_BIT_EXT_HOLD 1
`define PHVC_BIT_LDCMP_EN 3
`define PHVC_BIT_CAL_DONE 6
`define PHVC_LDPIN_CURRENT_SOURCE_LOCK_DETECT 6'h04
`define PHVC_CAL_CYCLES 13'd4400
`define PHVC_CALDIV_MAX_HZ 6250000
`define PHVC_RST_PLLCTL 8'h00
`define PHVC_RST_HOLDCTL 8'h00
`endif

// ---- hdl/phvc_pkg.sv ----
// Types for the PLL holdover and VCO calibration control block.
// Assumes the constants header is included by the top module.
package phvc_pkg;
  typedef enum logic [1:0] {HOLD_RUN, HOLD_TRI, HOLD_REARM} phvc_hold_t;
  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} phvc_cal_t;
endpackage

// ---- hdl/phvc_top.sv ----
// PLL holdover, lock count, frequency monitor select and VCO calibration control.
// Assumes lock, reference edge and monitor inputs are asynchronous to sys_clk.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "phvc_consts.svh"
module phvc_top (
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic sys_rst, // Synchronous active-high reset
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic refEdgeIn, // Reference edge at the phase detector
  input wire logic inWindowIn, // Detector cycle inside lock window
  input wire logic outUnlockIn, // Detector cycle beyond unlock threshold
  input wire logic lockPinIn, // Sensed lock detect pin level
  input wire logic refSwitchIn, // Reference switchover in progress
  input wire logic extHoldReqIn, // External holdover request, active high
  input wire logic [2:0] freqLowIn, // Raw frequency-low flags ref1, ref2, vco/clk
  input wire logic clkInSelIn, // External clock input selected instead of VCO
  input wire logic autoLoadIn, // Nonvolatile auto-load finished at power-up
  output logic chargePumpTriOut, // Charge pump high impedance
  output logic bCounterRstOut, // B counter reset pulse
  output logic digitalLockOut, // Digital lock indicator
  output logic [2:0] freqMonOut, // Frequency monitor flags
  output logic vcoMonIsClkOut, // VCO monitor is watching the clock input
  output logic monThreshExtOut, // Extended reference monitor threshold
  output logic [5:0] ldPinModeOut, // Lock detect pin control code
  output logic csdldModeOut, // Current source lock detect selected
  output logic calSyncOut, // Internal sync holding outputs static
  output logic loopOpenOut // Loop held open for tuning
);
  import phvc_pkg::*;

  // Async inputs through two flops
  logic [10:0] syncA_ff, syncB_ff;
  wire logic [10:0] rawIn = {autoLoadIn, clkInSelIn, freqLowIn, extHoldReqIn, refSwitchIn,
                             lockPinIn, outUnlockIn, inWindowIn, refEdgeIn};
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      syncA_ff <= 11'h000;
      syncB_ff <= 11'h000;
    end else begin
      syncA_ff <= rawIn;
      syncB_ff <= syncA_ff;
    end
  end
  logic refPrev_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) refPrev_ff <= 1'b0;
    else refPrev_ff <= syncB_ff[0];
  end
  wire logic refRise = syncB_ff[0] & ~refPrev_ff;
  wire logic inWin = syncB_ff[1];
  wire logic outUnl = syncB_ff[2];
  wire logic ldPin = syncB_ff[3];
  wire logic refSw = syncB_ff[4];
  wire logic extReq = syncB_ff[5];
  wire logic [2:0] fLow = syncB_ff[8:6];
  wire logic clkSel = syncB_ff[9];
  wire logic autoLd = syncB_ff[10];

  // Register state
  logic [7:0] pllCtl_ff, ldPinCtl_ff, holdCtl_ff, refSel_ff, vcoDiv_ff;
  logic calCommit_ff;
  logic calCommitPrev_ff;

  // AXI write channel
  logic awHeld_ff, wHeld_ff;
  logic [11:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  wire logic awTake = s_axi_awvalid & s_axi_awready;
  wire logic wTake = s_axi_wvalid & s_axi_wready;
  wire logic doWrite = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
  wire logic [11:0] wIdx = awAddr_ff;
  wire logic wLane0 = wStrb_ff[0];

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `PHVC_ADDR_PLLCTL) || (a == `PHVC_ADDR_LDPIN) || (a == `PHVC_ADDR_REFSEL)
          || (a == `PHVC_ADDR_HOLDCTL) || (a == `PHVC_ADDR_STATUS)
          || (a == `PHVC_ADDR_VCODIV) || (a == `PHVC_ADDR_UPDATE);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= 12'h000;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (awTake) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr[13:2];
        s_axi_awready <= 1'b0;
      end
      if (wTake) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wIdx) ? 2'h0 : 2'h3;
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Only the PLL control register is staged and commits on the update strobe, like the part's update-all
  logic [7:0] stPll_ff;
  wire logic wrStage = doWrite & wLane0;
  wire logic updStrobe = wrStage & (wIdx == `PHVC_ADDR_UPDATE) & wData_ff[0];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stPll_ff <= `PHVC_RST_PLLCTL;
      pllCtl_ff <= `PHVC_RST_PLLCTL;
      ldPinCtl_ff <= 8'h00;
      holdCtl_ff <= `PHVC_RST_HOLDCTL;
      refSel_ff <= 8'h00;
      vcoDiv_ff <= 8'h00;
    end else begin
      if (wrStage && wIdx == `PHVC_ADDR_PLLCTL) stPll_ff <= wData_ff[7:0];
      if (wrStage && wIdx == `PHVC_ADDR_LDPIN) ldPinCtl_ff <= wData_ff[7:0];
      if (wrStage && wIdx == `PHVC_ADDR_REFSEL) refSel_ff <= wData_ff[7:0];
      if (wrStage && wIdx == `PHVC_ADDR_HOLDCTL) holdCtl_ff <= wData_ff[7:0];
      // Software keeps this field static while calibrating
      if (wrStage && wIdx == `PHVC_ADDR_VCODIV) vcoDiv_ff <= wData_ff[7:0];
      if (updStrobe) pllCtl_ff <= stPll_ff;
    end
  end
  wire logic calBit = pllCtl_ff[`PHVC_BIT_CAL];
  wire logic [1:0] calDivSel = pllCtl_ff[`PHVC_BIT_CALDIV_LO +: 2];
  wire logic [1:0] ldCnt = pllCtl_ff[`PHVC_BIT_LDCNT_LO +: 2];
  wire logic dldDis = pllCtl_ff[`PHVC_BIT_DLD_DIS];
  wire logic holdEn = holdCtl_ff[`PHVC_BIT_HOLD_EN];
  wire logic extMode = holdCtl_ff[`PHVC_BIT_EXT_HOLD];
  wire logic ldCmpEn = holdCtl_ff[`PHVC_BIT_LDCMP_EN];

  // Digital lock detector
  logic [3:0] lockRun_ff;
  logic digLock_ff;
  wire logic [3:0] lockNeed = (ldCnt == 2'h0) ? 4'h5 :
                              (ldCnt == 2'h1) ? 4'h8 : (ldCnt == 2'h2) ? 4'hA : 4'hF;
  always_ff @(posedge sys_clk) begin
    if (sys_rst || dldDis) begin
      lockRun_ff <= 4'h0;
      digLock_ff <= 1'b0;
    end else if (refRise) begin
      if (outUnl) begin
        lockRun_ff <= 4'h0;
        digLock_ff <= 1'b0;
      end else if (inWin) begin
        if (lockRun_ff + 4'h1 >= lockNeed) digLock_ff <= 1'b1;
        if (lockRun_ff != 4'hF) lockRun_ff <= lockRun_ff + 4'h1;
      end else begin
        lockRun_ff <= 4'h0;
      end
    end
  end

  // Holdover state machine
  phvc_hold_t hold_ff;
  logic bRst_ff;
  logic extPrev_ff;
  wire logic ldSensed = ldCmpEn ? ldPin : 1'b1;
  // Loss is the digital lock dropping while the sensed pin still reads high
  wire logic autoLoss = ~extMode & ~digLock_ff & ldSensed;
  wire logic extFall = extMode & extReq & ~extPrev_ff;
  wire logic enterHold = holdEn & (autoLoss | extFall | (~extMode & refSw & ~digLock_ff));
  wire logic leaveOk = extMode ? ~extReq : 1'b1;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_ff <= HOLD_RUN;
      bRst_ff <= 1'b0;
      extPrev_ff <= 1'b0;
    end else begin
      extPrev_ff <= extReq;
      bRst_ff <= 1'b0;
      unique case (hold_ff)
        HOLD_RUN: if (enterHold) hold_ff <= HOLD_TRI;
        HOLD_TRI: begin
          if (!holdEn) hold_ff <= HOLD_RUN;
          else if (refRise && leaveOk) begin
            hold_ff <= HOLD_REARM;
            bRst_ff <= 1'b1;
          end
        end
        HOLD_REARM: begin
          if (extMode && extFall && holdEn) hold_ff <= HOLD_TRI;
          else if (digLock_ff && ldSensed) hold_ff <= HOLD_RUN;
        end
      endcase
    end
  end
  assign chargePumpTriOut = (hold_ff == HOLD_TRI);
  assign bCounterRstOut = bRst_ff;
  assign digitalLockOut = digLock_ff;

  // Monitor and mode outputs
  logic [2:0] fMon_ff;
  logic clkMon_ff, thrExt_ff, current_source_lock_detect_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fMon_ff <= 3'h0;
      clkMon_ff <= 1'b0;
      thrExt_ff <= 1'b0;
      current_source_lock_detect_ff <= 1'b0;
    end else begin
      fMon_ff <= fLow;
      clkMon_ff <= clkSel;
      thrExt_ff <= ldPinCtl_ff[`PHVC_BIT_THRESH];
      current_source_lock_detect_ff <= (ldPinCtl_ff[5:0] == `PHVC_LDPIN_CURRENT_SOURCE_LOCK_DETECT);
    end
  end
  assign freqMonOut = fMon_ff;
  assign vcoMonIsClkOut = clkMon_ff;
  assign monThreshExtOut = thrExt_ff;
  assign ldPinModeOut = ldPinCtl_ff[5:0];
  assign csdldModeOut = current_source_lock_detect_ff;

  // Calibration divider: reference edges divided by 2,4,8,16
  logic [3:0] calDivCnt_ff;
  wire logic [3:0] divTop = (4'h2 << calDivSel) - 4'h1;
  wire logic calTick = refRise & (calDivCnt_ff == divTop);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) calDivCnt_ff <= 4'h0;
    else if (refRise) calDivCnt_ff <= (calDivCnt_ff >= divTop) ? 4'h0 : calDivCnt_ff + 4'h1;
  end

  // Calibration sequencer
  phvc_cal_t cal_ff;
  logic [12:0] calCnt_ff;
  logic autoPrev_ff;
  logic calPend_ff;
  wire logic calRise = calBit & ~calCommitPrev_ff;
  wire logic autoStart = autoLd & ~autoPrev_ff;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      calCommitPrev_ff <= 1'b0;
      calCommit_ff <= 1'b0;
      autoPrev_ff <= 1'b0;
      calPend_ff <= 1'b0;
      cal_ff <= CAL_IDLE;
      calCnt_ff <= 13'd0;
    end else begin
      calCommitPrev_ff <= calBit;
      calCommit_ff <= calBit;
      autoPrev_ff <= autoLd;
      if ((calRise || autoStart) && cal_ff != CAL_RUN) calPend_ff <= 1'b1;
      if (calPend_ff && cal_ff != CAL_RUN) begin
        cal_ff <= CAL_RUN;
        calCnt_ff <= 13'd0;
        calPend_ff <= 1'b0;
      end else if (cal_ff == CAL_RUN && calTick) begin
        if (calCnt_ff == `PHVC_CAL_CYCLES - 13'd1) cal_ff <= CAL_DONE;
        else calCnt_ff <= calCnt_ff + 13'd1;
      end
    end
  end
  assign calSyncOut = (cal_ff == CAL_RUN);
  assign loopOpenOut = (cal_ff == CAL_RUN);
  wire logic calDone = (cal_ff == CAL_DONE);

  // AXI read channel
  wire logic [11:0] rIdx = s_axi_araddr[13:2];
  wire logic [7:0] rByte =
      (rIdx == `PHVC_ADDR_PLLCTL) ? stPll_ff :
      (rIdx == `PHVC_ADDR_LDPIN) ? ldPinCtl_ff :
      (rIdx == `PHVC_ADDR_REFSEL) ? refSel_ff :
      (rIdx == `PHVC_ADDR_HOLDCTL) ? holdCtl_ff :
      (rIdx == `PHVC_ADDR_VCODIV) ? vcoDiv_ff :
      (rIdx == `PHVC_ADDR_STATUS) ?
        {1'b0, calDone, digLock_ff, chargePumpTriOut, 1'b0, fMon_ff} : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rByte};
      s_axi_rresp <= mapped(rIdx) ? 2'h0 : 2'h3;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  a_tri_on_loss: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hold_ff == HOLD_RUN && holdEn && !extMode && !digLock_ff && ldSensed) |=> chargePumpTriOut)
    else $error("holdover not entered on lock loss");
  a_tri_no_ref: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (chargePumpTriOut && holdEn && !refRise) |=> chargePumpTriOut)
    else $error("tri-state left without reference edge");
  a_brst_exit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bCounterRstOut |-> (hold_ff == HOLD_REARM && $past(chargePumpTriOut)))
    else $error("B counter reset without holdover exit");
  a_rearm_block: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hold_ff == HOLD_REARM && !digLock_ff && !extMode) |=> !chargePumpTriOut)
    else $error("holdover reentered before relock");
  a_hold_inhibit: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!holdEn && !chargePumpTriOut) |=> !chargePumpTriOut)
    else $error("holdover entered while disabled");
  a_unlock_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (refRise && outUnl && !dldDis) |=> !digitalLockOut)
    else $error("lock not dropped on unlock cycle");
  a_cal_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(calSyncOut) |-> !calDone)
    else $error("done set while calibration running");
  a_cal_length: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cal_ff == CAL_RUN && calTick && calCnt_ff != `PHVC_CAL_CYCLES - 13'd1) |=> calSyncOut)
    else $error("calibration ended early");
  a_current_source_lock_detect_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ldPinCtl_ff[5:0] == 6'h04) |=> csdldModeOut)
    else $error("current source mode not decoded");
endmodule // phvc_top

// ---- sim/phvc_ref_model.sv ----
// Reference source model: the detector-side reference edge seen by the block.
// Assumes the bench sets the half period and presence between edges.
`timescale 1ns/10ps
module phvc_ref_model (
  input wire logic sysClk, // Bench clock
  input wire logic refOn, // Reference present
  input wire logic [3:0] halfCycles, // Half period in clock cycles
  output logic refEdge, // Reference level at the detector
  output int riseCount // Rising edges since time zero
);
  int phase;
  initial begin
    refEdge = 1'b0;
    riseCount = 0;
    phase = 0;
  end
  // A lost reference stands low, so no stray edge ends a holdover
  always @(posedge sysClk) begin
    if (!refOn) begin
      phase <= 0;
      refEdge <= 1'b0;
    end else if (phase >= halfCycles - 1) begin
      phase <= 0;
      refEdge <= ~refEdge;
      if (!refEdge) riseCount <= riseCount + 1;
    end else begin
      phase <= phase + 1;
    end
  end
endmodule // phvc_ref_model

// ---- sim/tb_pll_holdover_vco_calibration.sv ----
// Self-checking bench for holdover, lock count, monitors and VCO calibration.
// Assumes the reference model drives the detector edge; the bench plays host.
`timescale 1ns/10ps
`include "phvc_consts.svh"
module tb_pll_holdover_vco_calibration;
  logic sysClk = 1'b0, sysRst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic inWin = 1'b0, outUnl = 1'b1, lockPin = 1'b0, extHold = 1'b0, clkSel = 1'b0;
  logic refOn = 1'b1, autoLd = 1'b0;
  logic [2:0] freqLow = 3'h0, freqMon;
  logic [3:0] halfCyc = 4'h4;
  logic refEdge, cpTri, bRst, dLock, monExt, current_source_lock_detect, calSync, loopOpen, vcoClk;
  logic [5:0] ldMode;
  int riseCount, errCount = 0, checkCount = 0, cycles = 0, start, n;
  int need[4] = '{5, 8, 10, 15};
  always #2 sysClk = ~sysClk;
  phvc_top u_dut (.sys_clk(sysClk), .sys_rst(sysRst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .refEdgeIn(refEdge), .inWindowIn(inWin),
    .outUnlockIn(outUnl), .lockPinIn(lockPin), .refSwitchIn(1'b0), .extHoldReqIn(extHold),
    .freqLowIn(freqLow), .clkInSelIn(clkSel), .autoLoadIn(autoLd), .chargePumpTriOut(cpTri),
    .bCounterRstOut(bRst), .digitalLockOut(dLock), .freqMonOut(freqMon),
    .vcoMonIsClkOut(vcoClk), .monThreshExtOut(monExt), .ldPinModeOut(ldMode),
    .csdldModeOut(current_source_lock_detect), .calSyncOut(calSync), .loopOpenOut(loopOpen));
  phvc_ref_model u_ref (.sysClk(sysClk), .refOn(refOn), .halfCycles(halfCyc),
    .refEdge(refEdge), .riseCount(riseCount));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axiWr(input logic [11:0] idx, input logic [31:0] v, output logic [1:0] rs);
    int k = 0;
    rs = 2'bxx;
    @(posedge sysClk);
    s_axi_awaddr <= {18'h0, idx, 2'h0};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (k < 100) begin
      @(posedge sysClk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        k = 100;
      end
    end
  endtask
  task automatic axiRd(input logic [11:0] idx, output logic [31:0] v, output logic [1:0] rs);
    int k = 0;
    rs = 2'bxx;
    v = 32'hx;
    @(posedge sysClk);
    s_axi_araddr <= {18'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (k < 100) begin
      @(posedge sysClk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rs = s_axi_rresp;
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        k = 100;
      end
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] v);
    logic [1:0] rs;
    axiWr(idx, v, rs);
    chk(rs, 32'h0);
  endtask
  task automatic rdChk(input logic [11:0] idx, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    axiRd(idx, v, rs);
    chk(rs, 32'h0);
    chk(v & m, e);
  endtask
  // Checks land five clocks after a rise: past the synchroniser, before the next edge
  task automatic waitRises(input int k);
    int t = riseCount + k;
    while (riseCount < t) @(posedge sysClk);
    repeat (5) @(posedge sysClk);
  endtask
  task automatic lockRun(input logic good, input int k);
    inWin <= good;
    outUnl <= ~good;
    waitRises(k);
  endtask
  task automatic lockTest(input logic [1:0] code, input int cnt);
    wr(`PHVC_ADDR_PLLCTL, {25'h0, code, 5'h00});
    wr(`PHVC_ADDR_UPDATE, 32'h1);
    lockRun(1'b0, 2);
    chk(dLock, 32'h0);
    lockRun(1'b1, cnt - 1);
    chk(dLock, 32'h0);
    lockRun(1'b1, 1);
    chk(dLock, 32'h1);
  endtask
  task automatic calWait();
    start = riseCount;
    repeat (8) @(posedge sysClk);
    chk({calSync, loopOpen}, 32'h3);
    rdChk(`PHVC_ADDR_STATUS, 32'h40, 32'h0);
    while (riseCount < start + 8790) @(posedge sysClk);
    rdChk(`PHVC_ADDR_STATUS, 32'h40, 32'h0);
    chk(calSync, 32'h1);
    while (riseCount < start + 8810) @(posedge sysClk);
    repeat (5) @(posedge sysClk);
    rdChk(`PHVC_ADDR_STATUS, 32'h40, 32'h40);
    chk({calSync, loopOpen}, 32'h0);
  endtask
  task automatic print_verdict();
    $display("Summary: %0d checks, %0d mismatches", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Two full calibrations dominate the run, about 71k cycles
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errCount++;
      $display("Timeout at cycle %0d", cycles);
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge sysClk);
    sysRst <= 1'b0;
    rdChk(`PHVC_ADDR_PLLCTL, 32'hFF, 32'h0);
    rdChk(`PHVC_ADDR_HOLDCTL, 32'hFF, 32'h0);
    axiRd(12'h100, d, r);
    chk(r, 32'h3);
    chk(d, 32'h0);
    axiWr(12'h100, 32'hFF, r);
    chk(r, 32'h3);
    axiWr(`PHVC_ADDR_STATUS, 32'h40, r);
    rdChk(`PHVC_ADDR_STATUS, 32'h40, 32'h0);
    $display("test registers done");
    wr(`PHVC_ADDR_LDPIN, 32'h04);
    @(posedge sysClk);
    chk({monExt, current_source_lock_detect, ldMode}, 32'h44);
    wr(`PHVC_ADDR_LDPIN, 32'h45);
    @(posedge sysClk);
    chk({monExt, current_source_lock_detect, ldMode}, 32'h85);
    rdChk(`PHVC_ADDR_LDPIN, 32'h7F, 32'h45);
    freqLow <= 3'h5;
    clkSel <= 1'b1;
    repeat (6) @(posedge sysClk);
    chk({vcoClk, freqMon}, 32'hD);
    rdChk(`PHVC_ADDR_STATUS, 32'h07, 32'h05);
    $display("test monitors done");
    for (int c = 3; c >= 0; c--) lockTest(c[1:0], need[c]);
    $display("test lock count done");
    wr(`PHVC_ADDR_HOLDCTL, 32'h01);
    lockRun(1'b0, 1);
    chk({dLock, cpTri}, 32'h1);
    refOn <= 1'b0;
    repeat (60) @(posedge sysClk);
    chk(cpTri, 32'h1);
    refOn <= 1'b1;
    n = 0;
    while (cpTri === 1'b1 && n < 40) begin
      @(posedge sysClk);
      n++;
    end
    chk({cpTri, bRst}, 32'h1);
    @(posedge sysClk);
    chk(bRst, 32'h0);
    lockRun(1'b0, 2);
    chk(cpTri, 32'h0);
    lockRun(1'b1, 5);
    lockRun(1'b0, 1);
    chk(cpTri, 32'h1);
    lockRun(1'b0, 1);
    chk(cpTri, 32'h0);
    wr(`PHVC_ADDR_HOLDCTL, 32'h09);
    lockRun(1'b1, 5);
    lockRun(1'b0, 1);
    chk(cpTri, 32'h0);
    lockPin <= 1'b1;
    lockRun(1'b1, 5);
    lockRun(1'b0, 1);
    chk(cpTri, 32'h1);
    lockRun(1'b0, 1);
    wr(`PHVC_ADDR_HOLDCTL, 32'h00);
    lockRun(1'b1, 5);
    lockRun(1'b0, 1);
    extHold <= 1'b1;
    repeat (8) @(posedge sysClk);
    chk(cpTri, 32'h0);
    extHold <= 1'b0;
    wr(`PHVC_ADDR_HOLDCTL, 32'h03);
    lockRun(1'b1, 5);
    lockRun(1'b0, 1);
    chk(cpTri, 32'h0);
    extHold <= 1'b1;
    repeat (8) @(posedge sysClk);
    chk(cpTri, 32'h1);
    extHold <= 1'b0;
    lockRun(1'b0, 2);
    chk(cpTri, 32'h0);
    wr(`PHVC_ADDR_HOLDCTL, 32'h00);
    $display("test holdover done");
    wr(`PHVC_ADDR_VCODIV, 32'h2);
    halfCyc <= 4'h2;
    wr(`PHVC_ADDR_PLLCTL, 32'h1);
    wr(`PHVC_ADDR_UPDATE, 32'h1);
    calWait();
    wr(`PHVC_ADDR_UPDATE, 32'h1);
    repeat (20) @(posedge sysClk);
    chk(calSync, 32'h0);
    wr(`PHVC_ADDR_PLLCTL, 32'h0);
    wr(`PHVC_ADDR_UPDATE, 32'h1);
    wr(`PHVC_ADDR_PLLCTL, 32'h1);
    wr(`PHVC_ADDR_UPDATE, 32'h1);
    calWait();
    autoLd <= 1'b1;
    repeat (8) @(posedge sysClk);
    chk(calSync, 32'h1);
    rdChk(`PHVC_ADDR_STATUS, 32'h40, 32'h0);
    $display("test calibration done");
    print_verdict();
  end
endmodule // tb_pll_holdover_vco_calibration
